// ---- hdl/isd_defines.svh ----
// constants for the two-wire status, interrupt and bit-rate block
`ifndef ISD_DEFINES_SVH
`define ISD_DEFINES_SVH

// special-function register address of the status register
`define ISD_STATUS_ADDR     8'hDD
`define ISD_STATUS_RESET    8'h00

// status field positions, bit 7 down to bit 0
`define ISD_BIT_GC          7
`define ISD_BIT_STOP        6
`define ISD_BIT_INTR        5
`define ISD_BIT_TX          4
`define ISD_BIT_BUSY        3
`define ISD_BIT_LOST        2
`define ISD_BIT_NACK        1
`define ISD_BIT_SLV         0

// general call address byte
`define ISD_GC_ADDR         8'h00

// oscillator divisors per rate code 000 .. 111
`define ISD_DIV_0           11'd32
`define ISD_DIV_1           11'd48
`define ISD_DIV_2           11'd60
`define ISD_DIV_3           11'd120
`define ISD_DIV_4           11'd240
`define ISD_DIV_5           11'd480
`define ISD_DIV_6           11'd960
`define ISD_DIV_7           11'd1920

`endif

// ---- hdl/isd_pkg.sv ----
// types shared by the two-wire status block
package isd_pkg;

    // phase of the generated master clock
    typedef enum logic [1:0] {
        ISD_PH_IDLE,
        ISD_PH_LOW,
        ISD_PH_HIGH
    } isd_phase_type;

    // complete register state of the status core
    typedef struct packed {
        logic          sda_s1;    // pin synchroniser stage 1
        logic          sda_s2;    // pin synchroniser stage 2
        logic          sda_p;     // previous synchronised level
        logic          scl_s1;
        logic          scl_s2;
        logic          gc;        // general call seen
        logic          stop;      // stop detected
        logic          intr;      // interrupt pending
        logic          tx;        // transmit mode
        logic          busy;      // bus busy
        logic          lost;      // arbitration lost
        logic          nack;      // no acknowledge response
        logic          slave_mode_flag;       // slave mode
        logic          selected;  // addressed slave in this transfer
        logic          irq;       // interrupt request out
        logic [7:0]    rdata;     // register read data
        isd_phase_type phase;     // master clock phase
        logic [10:0]   cnt;       // cycles left in phase
        logic          scl_oe;    // pull scl low
    } isd_core_type;

    // fifo pointer state
    typedef struct packed {
        logic [4:0] wr;
        logic [4:0] rd;
    } isd_fifo_ptr_type;

endpackage : isd_pkg

// ---- hdl/isd_fifo.sv ----
// byte fifo between the serial engine and the cpu side
module isd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    // clock and control
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    import isd_pkg::*;

    logic [WIDTH-1:0] mem [DEPTH];  // storage, no reset needed
    logic [AW:0]      wr_q;         // write pointer with wrap bit
    logic [AW:0]      rd_q;
    logic [AW:0]      wr_d;
    logic [AW:0]      rd_d;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // wrap bit distinguishes full from empty
    assign empty     = (wr_q == rd_q);
    assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_q[AW-1:0]];
    assign push      = ce && in_valid && !full;
    assign pop       = ce && out_ready && !empty;

    // next pointers
    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        if (push) begin
            wr_d = wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = rd_q + 1'b1;
        end
    end

    // pointer registers
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // storage write
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    // occupancy never passes the depth, which a wrapped pointer would show
    fifo_no_overrun_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (AW+1)'(wr_q - rd_q) <= (AW+1)'(DEPTH))
        else $error("fifo holds more than its depth");

endmodule : isd_fifo

// ---- hdl/isd_status_core.sv ----
// two-wire bus status register, interrupt conditions and master bit-rate divider
`include "isd_defines.svh"

module isd_status_core #(
    parameter int FIFO_DEPTH = 16
) (
    // clock, reset, freeze
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    // special-function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // control bits held elsewhere
    input  wire logic       engine_enable,
    input  wire logic       auto_ack_enable,
    input  wire logic [2:0] rate_select,
    input  wire logic [7:0] own_address_reg,
    input  wire logic       bus_irq_enable,
    input  wire logic       global_irq_enable,
    // serial engine state and events
    input  wire logic       engine_master,
    input  wire logic       engine_tx,
    input  wire logic       scl_run,
    input  wire logic       addr_done,
    input  wire logic [7:0] addr_byte,
    input  wire logic       byte_done,
    input  wire logic [7:0] byte_data,
    input  wire logic       ack_done,
    input  wire logic       ack_level,
    input  wire logic       arb_lost,
    output logic            byte_ready,
    // received and sent bytes toward the cpu
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic      [7:0] rx_data,
    // bus pins
    input  wire logic       sda_in,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    // interrupt request
    output logic            irq_req
);
    import isd_pkg::*;

    isd_core_type q;          // registered state
    isd_core_type d;          // next state
    logic         start_det;  // start seen on synchronised pins
    logic         stop_det;   // stop seen on synchronised pins
    logic         ev_addr;    // own address matched
    logic         ev_gc;      // general call accepted
    logic         ev_byte;    // qualifying byte completed
    logic         ev_stop;    // stop as selected slave
    logic         any_ev;     // any of the four events
    logic         st_wr;      // status register write
    logic [10:0]  div;        // selected divisor
    logic [10:0]  half_lo;    // low phase length
    logic [10:0]  half_hi;    // high phase length
    logic         clk_on;     // master clock wanted

    // rate code to divisor lookup
    function automatic logic [10:0] rate_div(input logic [2:0] code);
        case (code)
            3'h0:    rate_div = `ISD_DIV_0;
            3'h1:    rate_div = `ISD_DIV_1;
            3'h2:    rate_div = `ISD_DIV_2;
            3'h3:    rate_div = `ISD_DIV_3;
            3'h4:    rate_div = `ISD_DIV_4;
            3'h5:    rate_div = `ISD_DIV_5;
            3'h6:    rate_div = `ISD_DIV_6;
            default: rate_div = `ISD_DIV_7;
        endcase
    endfunction : rate_div

    // a byte completed while byte_ready is low is dropped, so the engine must stall on back-pressure
    isd_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .ce        (ce),
        .in_valid  (byte_done),
        .in_ready  (byte_ready),
        .in_data   (byte_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // conditions on the bus, judged after the synchroniser only
    assign start_det = q.scl_s2 && q.sda_p && !q.sda_s2;
    assign stop_det  = q.scl_s2 && !q.sda_p && q.sda_s2;

    // the four interrupt events
    assign ev_addr = addr_done && q.slave_mode_flag && auto_ack_enable
                     && (addr_byte[7:1] == own_address_reg[7:1]);
    assign ev_gc   = addr_done && q.slave_mode_flag && auto_ack_enable
                     && (addr_byte == `ISD_GC_ADDR);
    assign ev_byte = byte_done && (!q.slave_mode_flag || q.selected);
    assign ev_stop = stop_det && q.slave_mode_flag && q.selected;
    assign any_ev  = ev_addr || ev_gc || ev_byte || ev_stop;
    assign st_wr   = sfr_wr && (sfr_addr == `ISD_STATUS_ADDR);

    // divisor split into two near-equal halves
    assign div     = rate_div(rate_select);
    assign half_lo = {1'b0, div[10:1]};
    assign half_hi = div - half_lo;
    assign clk_on  = engine_enable && engine_master && scl_run;

    // next-state logic for every flag, the divider and the read port
    always_comb begin
        d = q;
        // two-stage synchroniser, third stage for edge detection
        d.sda_s1 = sda_in;
        d.sda_s2 = q.sda_s1;
        d.sda_p  = q.sda_s2;
        d.scl_s1 = scl_in;
        d.scl_s2 = q.scl_s1;

        // mode flags follow the engine
        d.slave_mode_flag = !engine_master;
        d.tx  = engine_tx;

        // bus busy and stop tracking
        if (start_det) begin
            d.busy = 1'b1;
            d.stop = 1'b0;
        end
        if (stop_det) begin
            d.busy = 1'b0;
            d.stop = 1'b1;
        end

        // addressed-slave state ends with every transfer
        if (start_det || stop_det) begin
            d.selected = 1'b0;
        end
        if (ev_addr) begin
            d.selected = 1'b1;
        end

        // general call flag, set wins over a simultaneous clear
        if (start_det || stop_det) begin
            d.gc = 1'b0;
        end
        if (addr_done && q.slave_mode_flag && addr_byte == `ISD_GC_ADDR) begin
            d.gc = 1'b1;
        end

        // lost flag clears at a new start, the loss itself wins
        if (start_det) begin
            d.lost = 1'b0;
        end
        if (arb_lost && engine_master) begin
            d.lost = 1'b1;
        end
        if (q.gc && engine_master) begin
            d.lost = 1'b1;
        end

        // acknowledge sample after a transmitted byte
        if (ack_done && q.tx) begin
            d.nack = ack_level;
        end

        // pending flag: software may write it, an event always wins
        if (st_wr) begin
            d.intr = sfr_wdata[`ISD_BIT_INTR];
        end
        if (any_ev) begin
            d.intr = 1'b1;
        end
        d.irq = q.intr && engine_enable && bus_irq_enable
                && global_irq_enable;

        // registered read of the status byte, zero elsewhere
        d.rdata = 8'h00;
        if (sfr_rd && sfr_addr == `ISD_STATUS_ADDR) begin
            d.rdata = {q.gc, q.stop, q.intr, q.tx,
                       q.busy, q.lost, q.nack, q.slave_mode_flag};
        end

        // master clock: low half then high half, restart when idle
        case (q.phase)
            ISD_PH_IDLE: begin
                d.scl_oe = 1'b0;
                if (clk_on) begin
                    d.phase  = ISD_PH_LOW;
                    d.cnt    = half_lo - 11'd1;
                    d.scl_oe = 1'b1;
                end
            end
            ISD_PH_LOW: begin
                if (!clk_on) begin
                    d.phase  = ISD_PH_IDLE;
                    d.scl_oe = 1'b0;
                end else if (q.cnt == 11'd0) begin
                    d.phase  = ISD_PH_HIGH;
                    d.cnt    = half_hi - 11'd1;
                    d.scl_oe = 1'b0;
                end else begin
                    d.cnt = q.cnt - 11'd1;
                end
            end
            ISD_PH_HIGH: begin
                // the count runs on while the line is still seen low, so an
                // unstretched period is exactly the divisor; the line reads high
                // two cycles late, well inside the shortest high half
                if (!clk_on) begin
                    d.phase = ISD_PH_IDLE;
                end else if (q.cnt != 11'd0) begin
                    d.cnt = q.cnt - 11'd1;
                end else if (q.scl_s2) begin
                    d.phase  = ISD_PH_LOW;
                    d.cnt    = half_lo - 11'd1;
                    d.scl_oe = 1'b1;
                end
                // a stretching slave holds scl low: stay here until it lets go
            end
            default: begin
                d.phase  = ISD_PH_IDLE;
                d.scl_oe = 1'b0;
            end
        endcase
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            q        <= '0;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
            q.sda_p  <= 1'b1;
            q.scl_s1 <= 1'b1;
            q.scl_s2 <= 1'b1;
            q.slave_mode_flag    <= 1'b0;
            q.phase  <= ISD_PH_IDLE;
        end else if (ce) begin
            q <= d;
        end
    end

    // outputs from flip-flops, scl_out tied low
    assign sfr_rdata = q.rdata;
    assign irq_req   = q.irq;
    assign scl_oe    = q.scl_oe;
    assign scl_out   = 1'b0;

    // ---- assertions guarding the documented behaviour ----

    sequence s_any_event;
        ce && any_ev;
    endsequence

    // data seen low with the clock high, then rising: the two steps of a stop
    sequence s_low_then_stop;
        ce && q.scl_s2 && !q.sda_s2 ##1 ce && stop_det;
    endsequence

    // the high half has run out, whatever the line does
    sequence s_high_expired;
        ce && clk_on && q.phase == ISD_PH_HIGH && q.cnt == 11'd0;
    endsequence

    irq_gating_a: assert property (@(posedge core_clk) disable iff (!nrst)
        ce |=> (q.irq == ($past(q.intr) && $past(engine_enable)
               && $past(bus_irq_enable) && $past(global_irq_enable))))
        else $error("interrupt request not gated by enables");

    event_sets_a: assert property (@(posedge core_clk) disable iff (!nrst)
        s_any_event |=> q.intr)
        else $error("pending flag missed an event");

    intr_sticky_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (q.intr && !(ce && st_wr)) |=> q.intr)
        else $error("pending flag cleared without a write");

    busy_track_a: assert property (@(posedge core_clk) disable iff (!nrst)
        ce && start_det && !stop_det |=> q.busy ##0 (!ce || !stop_det) [*1])
        else $error("busy flag not set by start");

    busy_stop_a: assert property (@(posedge core_clk) disable iff (!nrst)
        s_low_then_stop |=> !q.busy && q.stop)
        else $error("stop did not clear busy");

    gc_master_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (ce && q.gc && engine_master) |=> q.lost)
        else $error("general call as master did not set lost");

    nack_capture_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (ce && ack_done && q.tx) |=> (q.nack == $past(ack_level)))
        else $error("no-ack flag not taken from acknowledge bit");

    select_own_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (ce && $rose(q.selected)) |-> $past(ev_addr))
        else $error("selected without own address match");

    low_length_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (ce && q.phase == ISD_PH_LOW && q.cnt == 11'd0 && clk_on)
        |=> q.phase == ISD_PH_HIGH && q.cnt == $past(half_hi) - 11'd1)
        else $error("master clock phase length wrong");

    writes_ignored_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (ce && st_wr && !start_det && !stop_det && !addr_done && !arb_lost
         && !q.gc) |=> (q.busy == $past(q.busy)) && (q.lost == $past(q.lost)))
        else $error("status write altered a read-only bit");

    stretch_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
        s_high_expired ##0 !q.scl_s2 |=> q.phase == ISD_PH_HIGH && !q.scl_oe)
        else $error("master clock did not wait for a held line");

    high_end_a: assert property (@(posedge core_clk) disable iff (!nrst)
        s_high_expired ##0 q.scl_s2 |=> q.phase == ISD_PH_LOW && q.scl_oe
                                        && q.cnt == $past(half_lo) - 11'd1)
        else $error("master clock high half did not end on time");

    gc_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (ce && (start_det || stop_det) && !addr_done) |=> !q.gc)
        else $error("general call flag survived a start or stop");

    tx_follow_a: assert property (@(posedge core_clk) disable iff (!nrst)
        ce |=> q.tx == $past(engine_tx))
        else $error("transmit flag does not follow the engine");

endmodule : isd_status_core

// ---- tb/isd_bus_partner.sv ----
// far-side bus model: another master making start and stop conditions
module isd_bus_partner (
    // clock and pin levels
    input  wire logic core_clk,
    input  wire logic scl_oe,
    output logic      sda_line,
    output logic      scl_line
);
    timeunit 1ns;
    timeprecision 1ps;

    logic scl_drv;  // far side clock level, high = released

    // open drain clock: whoever pulls low wins, the pull-up gives high otherwise
    assign scl_line = scl_drv & ~scl_oe;

    // both lines released at power-up, so the pull-ups hold them high
    initial begin
        sda_line = 1'b1;
        scl_drv  = 1'b1;
    end

    // one bus step, moved just after an edge, then held long enough for the synchroniser
    task automatic step(input logic sda_v, input logic scl_v);
        @(negedge core_clk);
        sda_line = sda_v;
        scl_drv  = scl_v;
        repeat (4) @(negedge core_clk);
    endtask : step

    // start: data falls while the clock is high, then the clock is pulled low
    task automatic gen_start();
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b0);
    endtask : gen_start

    // stop: data rises while the clock is high, leaving the bus released
    task automatic gen_stop();
        step(1'b0, 1'b0);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
    endtask : gen_stop
endmodule : isd_bus_partner

// ---- tb/i2c_status_irq_and_clock_divider_tb.sv ----
// self-checking bench for the two-wire status, interrupt and bit-rate core
module i2c_status_irq_and_clock_divider_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       core_clk, nrst, ce, sfr_wr, sfr_rd, engine_enable, auto_ack_enable;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, own_address_reg, addr_byte, byte_data, rx_data;
    logic [2:0] rate_select;
    logic       bus_irq_enable, global_irq_enable, engine_master, engine_tx, scl_run;
    logic       addr_done, byte_done, ack_done, ack_level, arb_lost, byte_ready;
    logic       rx_valid, rx_ready, sda_in, scl_in, scl_oe, scl_out, irq_req;
    int         err_count, tests_run, cyc;
    int         div_tab[8] = '{32, 48, 60, 120, 240, 480, 960, 1920};

    isd_status_core #(.FIFO_DEPTH(16)) dut_u (
        .core_clk(core_clk), .nrst(nrst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .engine_enable(engine_enable), .auto_ack_enable(auto_ack_enable),
        .rate_select(rate_select), .own_address_reg(own_address_reg),
        .bus_irq_enable(bus_irq_enable), .global_irq_enable(global_irq_enable),
        .engine_master(engine_master), .engine_tx(engine_tx), .scl_run(scl_run),
        .addr_done(addr_done), .addr_byte(addr_byte), .byte_done(byte_done),
        .byte_data(byte_data), .ack_done(ack_done), .ack_level(ack_level),
        .arb_lost(arb_lost), .byte_ready(byte_ready), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .sda_in(sda_in), .scl_in(scl_in),
        .scl_out(scl_out), .scl_oe(scl_oe), .irq_req(irq_req));

    isd_bus_partner bus_u (.core_clk(core_clk), .scl_oe(scl_oe), .sda_line(sda_in),
        .scl_line(scl_in));

    // verdict and end of run, reached from the main sequence or the hang guard
    task automatic stop_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    // single comparison for every kind of result, widened to 16 bits
    task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk_val

    // register write: strobe held over exactly one sampling edge
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge core_clk);
        sfr_wr = 1'b0;
    endtask : reg_wr

    // register read; data is registered and stands until the next edge
    task automatic status_is(input string n, input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge core_clk);
        sfr_rd = 1'b0;
        chk_val(n, {8'h00, e}, {8'h00, sfr_rdata});
    endtask : status_is

    // one-cycle engine event: 0 address, 1 byte, 2 acknowledge, 3 arbitration loss
    task automatic ev(input int k);
        @(negedge core_clk);
        addr_done = (k == 0);
        byte_done = (k == 1);
        ack_done  = (k == 2);
        arb_lost  = (k == 3);
        @(negedge core_clk);
        {addr_done, byte_done, ack_done, arb_lost} = 4'h0;
    endtask : ev

    // reset values and an unmapped read
    task automatic t_reset();
        status_is("reset status", 8'hDD, 8'h00);
        status_is("unmapped read", 8'hDE, 8'h00);
        chk_val("reset irq", 16'h0, {15'h0, irq_req});
        chk_val("reset fifo", 16'h1, {14'h0, rx_valid, byte_ready});
    endtask : t_reset

    // master byte event, enable gating, write masking and clearing
    task automatic t_master_irq();
        engine_tx = 1'b1;
        ev(1);
        status_is("master byte", 8'hDD, 8'h30);
        chk_val("irq masked", 16'h0, {15'h0, irq_req});
        bus_irq_enable = 1'b1;
        repeat (3) @(negedge core_clk);
        chk_val("irq no global", 16'h0, {15'h0, irq_req});
        global_irq_enable = 1'b1;
        repeat (3) @(negedge core_clk);
        chk_val("irq enabled", 16'h1, {15'h0, irq_req});
        engine_enable = 1'b0;
        repeat (3) @(negedge core_clk);
        chk_val("irq uninit", 16'h0, {15'h0, irq_req});
        engine_enable = 1'b1;
        reg_wr(8'hDD, 8'hFF);
        status_is("write ones", 8'hDD, 8'h30);
        reg_wr(8'hDE, 8'h00);
        status_is("unmapped write", 8'hDD, 8'h30);
        reg_wr(8'hDD, 8'h00);
        status_is("pending cleared", 8'hDD, 8'h10);
        repeat (2) @(negedge core_clk);
        chk_val("irq cleared", 16'h0, {15'h0, irq_req});
    endtask : t_master_irq

    // acknowledge, arbitration loss, start and stop flags in master mode
    task automatic t_flags();
        ack_level = 1'b1;
        ev(2);
        status_is("no ack", 8'hDD, 8'h12);
        ack_level = 1'b0;
        ev(2);
        status_is("ack", 8'hDD, 8'h10);
        ev(3);
        status_is("lost", 8'hDD, 8'h14);
        bus_u.gen_start();
        status_is("start busy", 8'hDD, 8'h18);
        bus_u.gen_stop();
        status_is("stop seen", 8'hDD, 8'h50);
    endtask : t_flags

    // one slave transfer; hit says whether the address selects us
    task automatic slave_xfer(input logic [7:0] a, input logic sel);
        logic [7:0] hit;
        hit = sel ? 8'h20 : 8'h00;
        bus_u.gen_start();
        status_is("slave start", 8'hDD, 8'h09);
        addr_byte = a;
        ev(0);
        status_is("slave address", 8'hDD, 8'h09 | hit);
        reg_wr(8'hDD, 8'h00);
        ev(1);
        status_is("slave byte", 8'hDD, 8'h09 | hit);
        reg_wr(8'hDD, 8'h00);
        bus_u.gen_stop();
        status_is("slave stop", 8'hDD, 8'h41 | hit);
        reg_wr(8'hDD, 8'h00);
    endtask : slave_xfer

    // general call as slave, then seen while master
    task automatic t_gc();
        bus_u.gen_start();
        addr_byte = 8'h00;
        ev(0);
        status_is("general call", 8'hDD, 8'hA9);
        reg_wr(8'hDD, 8'h00);
        engine_master = 1'b1;
        status_is("call as master", 8'hDD, 8'h8C);
        bus_u.gen_stop();
        status_is("call cleared", 8'hDD, 8'h44);
    endtask : t_gc

    // both halves of the generated clock per rate code 1 to 7, a held line, then idle
    task automatic t_rate();
        int n;
        for (int c = 1; c < 8; c++) begin
            @(negedge core_clk);
            rate_select = c[2:0];
            scl_run     = 1'b1;
            n = 0;
            while (scl_oe !== 1'b1 && n < 10) begin
                @(negedge core_clk);
                n++;
            end
            n = 0;
            while (scl_oe === 1'b1 && n < 2000) begin
                @(negedge core_clk);
                n++;
            end
            chk_val("scl low cycles", 16'(div_tab[c] / 2), 16'(n));
            n = 0;
            while (scl_oe === 1'b0 && n < 2000) begin
                @(negedge core_clk);
                n++;
            end
            chk_val("scl high cycles", 16'(div_tab[c] - div_tab[c] / 2), 16'(n));
            scl_run = 1'b0;
            repeat (3) @(negedge core_clk);
        end
        // the far side holds the line low past the high half, so the clock must wait
        @(negedge core_clk);
        rate_select = 3'h1;
        scl_run     = 1'b1;
        repeat (12) bus_u.step(1'b1, 1'b0);
        chk_val("scl stretched", 16'h0, {15'h0, scl_oe});
        bus_u.step(1'b1, 1'b1);
        chk_val("scl resumed", 16'h1, {15'h0, scl_oe});
        scl_run = 1'b0;
        repeat (2) @(negedge core_clk);
        chk_val("scl idle", 16'h0, {15'h0, scl_oe});
        chk_val("scl drive level", 16'h0, {15'h0, scl_out});
    endtask : t_rate

    // fill the byte buffer until it refuses, then drain it in order
    task automatic t_fifo();
        rx_ready = 1'b0;
        for (int i = 0; i < 17; i++) begin
            chk_val("byte_ready", 16'(i < 16), {15'h0, byte_ready});
            byte_data = 8'(8'h40 + i);
            ev(1);
        end
        @(negedge core_clk);
        rx_ready = 1'b1;
        for (int i = 0; i < 16; i++) begin
            chk_val("rx head", 16'(9'h140 + i), {7'h0, rx_valid, rx_data});
            @(negedge core_clk);
        end
        chk_val("rx empty", 16'h0, {15'h0, rx_valid});
        // with the clock enable low nothing is taken: no byte, no event
        reg_wr(8'hDD, 8'h00);
        ce = 1'b0;
        ev(1);
        ce = 1'b1;
        chk_val("frozen push", 16'h0, {15'h0, rx_valid});
        status_is("frozen status", 8'hDD, 8'h54);
    endtask : t_fifo

    // free-running 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // hang guard: the whole run needs well under this many cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            stop_test();
        end
    end

    // main sequence
    initial begin
        {nrst, sfr_wr, sfr_rd, bus_irq_enable, global_irq_enable, scl_run} = 6'h00;
        {addr_done, byte_done, ack_done, ack_level, arb_lost, engine_tx} = 6'h00;
        {sfr_addr, sfr_wdata, addr_byte, byte_data} = 32'h0;
        {ce, engine_enable, engine_master, rx_ready, auto_ack_enable} = 5'h1E;
        own_address_reg = 8'h54;
        rate_select     = 3'h1;
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
        t_reset();
        t_master_irq();
        t_flags();
        {engine_master, engine_tx, auto_ack_enable} = 3'h1;
        slave_xfer(8'h55, 1'b1);
        slave_xfer(8'h20, 1'b0);
        t_gc();
        t_rate();
        engine_tx = 1'b1;
        t_fifo();
        stop_test();
    end
endmodule : i2c_status_irq_and_clock_divider_tb
